// ==== rtcd_regs.sv ====
// Purpose: calendar date and alarm value registers behind an apb slave
// Assumes: time_i and tick_i come from the time counter outside
// Notes: value fields keep no reset, control state resets
// Notes on behaviour
// - date year is two bcd digits, tens in 31:28, units in 27:24
// - date month tens in bit 20, units in 19:16
// - date day of month tens in 13:12, units in 11:8
// - date weekday in bits 2:0, values 0 to 6
// - date writes land only while clock write enable, ctrl bit 3, is set
// - unassigned bits of date and alarm registers read zero, ignore writes
// - alarm hour tens in 29:28, units in 27:24
// - alarm minute tens in 22:20, units in 19:16
// - alarm second tens in 14:12, units in 11:8
// - alarm month tens in bit 20, units 19:16, upper bits zero
// - alarm day of month tens in 13:12, units in 11:8
// - alarm weekday in bits 2:0, values 0 to 6
// - bcd value fields are undefined after reset until written
// - write enable can be set only after the unlock key sequence
// - four-bit period code picks half-second up to yearly, higher reserved
`timescale 1ns/1ps
`default_nettype none
module rtcd_regs
  import rtcd_pkg::*;
#(
  parameter int AW = 8
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // time source
  input wire rtcd_time_t time_i,
  input wire logic tick_i,
  // events
  output logic alarm_evt_o,
  output logic irq_o
);
  rtcd_state_t q, next_q;
  logic [7:0] addr;
  logic setup, wr_done, rd_done;
  logic match, whole_sec;
  logic [IRQ_W-1:0] stat, imask, set_v, clr_v;
  rtcd_date_t wd_date;
  rtcd_time_t wd_time;
  logic [31:0] rd_v;
  logic hit;

  assign addr = paddr_i[7:0];
  assign setup = psel_i & ~penable_i;
  assign wr_done = psel_i & penable_i & q.pready & pwrite_i;
  assign rd_done = psel_i & penable_i & q.pready & ~pwrite_i;
  assign whole_sec = q.half;

  rtcd_match u_match (
    .cur_time_i(time_i),
    .cur_date_i(q.date),
    .alm_time_i(q.atime),
    .alm_date_i(q.adate),
    .alarm_period_mask_i(q.alarm_period_mask),
    .whole_sec_i(whole_sec),
    .match_o(match)
  );

  assign set_v = {q.refused, q.alarm_evt};
  assign clr_v = (rd_done && addr == OFS_STAT) ? q.rd_seen : '0;

  rtcd_irq #(
    .W(IRQ_W)
  ) u_irq (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .set_i(set_v),
    .clr_i(clr_v),
    .mask_we_i(wr_done && addr == OFS_IMASK),
    .mask_wd_i(pwdata_i[IRQ_W-1:0]),
    .stat_o(stat),
    .mask_o(imask),
    .irq_o(irq_o)
  );

  // written values with unassigned bits forced to zero
  always_comb begin
    wd_date = rtcd_date_t'(pwdata_i);
    wd_date.pad_hi = '0;
    wd_date.pad_mid = '0;
    wd_date.pad_lo = '0;
    wd_time = rtcd_time_t'(pwdata_i);
    wd_time.pad_hr = '0;
    wd_time.pad_min = '0;
    wd_time.pad_sec = '0;
    wd_time.pad_lo = '0;
  end

  // read mux, sampled in the setup phase
  always_comb begin
    rd_v = '0;
    hit = 1'b1;
    case (addr)
      OFS_CTRL: begin
        rd_v[CTRL_WREN_BIT] = q.wren;
        rd_v[CTRL_OPEN_BIT] = q.unlock == UL_OPEN;
      end
      OFS_UNLOCK: rd_v = '0;
      OFS_ALCTL: begin
        rd_v[ALCTL_EN_BIT] = q.alarm_en;
        rd_v[ALCTL_MASK_LSB+:4] = q.alarm_period_mask;
      end
      OFS_DATE: rd_v = q.date;
      OFS_ATIME: rd_v = q.atime;
      OFS_ADATE: rd_v = {8'h00, q.adate[23:0]};
      OFS_STAT: rd_v[IRQ_W-1:0] = stat;
      OFS_IMASK: rd_v[IRQ_W-1:0] = imask;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    next_q = q;
    next_q.alarm_evt = 1'b0;
    next_q.refused = 1'b0;
    next_q.pready = setup;
    if (setup) begin
      next_q.prdata = rd_v;
      next_q.pslverr = ~hit;
      next_q.rd_seen = (addr == OFS_STAT) ? stat : '0;
    end
    if (tick_i) begin
      next_q.half = ~q.half;
      next_q.alarm_evt = q.alarm_en & match;
    end
    if (wr_done) begin
      if (addr != OFS_UNLOCK && addr != OFS_CTRL) begin
        next_q.unlock = UL_IDLE;
      end
      case (addr)
        OFS_UNLOCK: begin
          if (pwdata_i == UNLOCK_KEY1) begin
            next_q.unlock = UL_KEY1;
          end else if (pwdata_i == UNLOCK_KEY2 && q.unlock == UL_KEY1) begin
            next_q.unlock = UL_OPEN;
          end else begin
            next_q.unlock = UL_IDLE;
          end
        end
        OFS_CTRL: begin
          // set only when open, clear always
          if (!pwdata_i[CTRL_WREN_BIT] || q.unlock == UL_OPEN) begin
            next_q.wren = pwdata_i[CTRL_WREN_BIT];
          end
          next_q.unlock = UL_IDLE;
        end
        OFS_ALCTL: begin
          next_q.alarm_en = pwdata_i[ALCTL_EN_BIT];
          next_q.alarm_period_mask = pwdata_i[ALCTL_MASK_LSB+:4];
        end
        OFS_DATE: begin
          if (q.wren) begin
            next_q.date = wd_date;
          end else begin
            next_q.refused = 1'b1;
          end
        end
        OFS_ATIME: next_q.atime = wd_time;
        OFS_ADATE: begin
          next_q.adate = wd_date;
          next_q.adate.year_tens_digit = '0;
          next_q.adate.year_units_digit = '0;
        end
        default: next_q.unlock = q.unlock;
      endcase
    end
    // control resets, value fields stay undefined
    if (!nrst_i) begin
      next_q.unlock = UL_IDLE;
      next_q.wren = 1'b0;
      next_q.alarm_en = 1'b0;
      next_q.alarm_period_mask = '0;
      next_q.half = 1'b0;
      next_q.prdata = '0;
      next_q.pready = 1'b0;
      next_q.pslverr = 1'b0;
      next_q.rd_seen = '0;
      next_q.alarm_evt = 1'b0;
      next_q.refused = 1'b0;
      next_q.date.pad_hi = '0;
      next_q.date.pad_mid = '0;
      next_q.date.pad_lo = '0;
      next_q.atime.pad_hr = '0;
      next_q.atime.pad_min = '0;
      next_q.atime.pad_sec = '0;
      next_q.atime.pad_lo = '0;
      next_q.adate.pad_hi = '0;
      next_q.adate.pad_mid = '0;
      next_q.adate.pad_lo = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    q <= next_q;
  end

  assign prdata_o = q.prdata;
  assign pready_o = q.pready;
  assign pslverr_o = q.pslverr;
  assign alarm_evt_o = q.alarm_evt;

  // checks
  sequence s_wr(logic [7:0] a);
    psel_i && penable_i && pready_o && pwrite_i && addr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    psel_i && !penable_i && !pwrite_i && addr == a;
  endsequence

  date_gate_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    s_wr(OFS_DATE) ##0 !q.wren |=> $stable(q.date) && q.refused)
    else $error("date changed while write enable clear");
  date_store_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    s_wr(OFS_DATE) ##0 q.wren |=> q.date == (($past(pwdata_i)) & 32'hff1f_3f07))
    else $error("date store wrong");
  date_resv_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    s_rd(OFS_DATE) |=> (prdata_o & 32'h00e0_c0f8) == 32'h0)
    else $error("date reserved bits not zero");
  atime_resv_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    s_wr(OFS_ATIME) |=> (q.atime & 32'hc080_80ff) == 32'h0)
    else $error("alarm time reserved bits kept");
  adate_top_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    s_rd(OFS_ADATE) |=> prdata_o[31:21] == 11'h000)
    else $error("alarm date upper bits not zero");
  wren_unlock_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $rose(q.wren) |-> $past(q.unlock) == UL_OPEN)
    else $error("write enable set without unlock");
  rsvd_code_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    tick_i && q.alarm_period_mask > 4'h9 |=> !alarm_evt_o)
    else $error("alarm on reserved period code");
  alarm_cause_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    alarm_evt_o |-> $past(tick_i) && $past(q.alarm_en) && $past(match))
    else $error("alarm without match");
  half_every_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    tick_i && q.alarm_en && q.alarm_period_mask == 4'h0
      |=> alarm_evt_o ##1 !alarm_evt_o || $past(tick_i, 1))
    else $error("half second alarm missed");
  irq_level_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    alarm_evt_o && imask[IRQ_ALARM_BIT] |=> irq_o)
    else $error("unmasked alarm did not raise interrupt");
  apb_ready_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  // stored values, read path, status and phase
  atime_store_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    s_wr(OFS_ATIME) |=> q.atime == ($past(pwdata_i) & 32'h3f7f_7f00))
    else $error("alarm time store wrong");
  adate_store_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    s_wr(OFS_ADATE) |=> q.adate == ($past(pwdata_i) & 32'h001f_3f07))
    else $error("alarm date store wrong");
  date_read_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    s_rd(OFS_DATE) |=> prdata_o == $past(q.date))
    else $error("date read data wrong");
  atime_read_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    s_rd(OFS_ATIME) |=> prdata_o == $past(q.atime))
    else $error("alarm time read data wrong");
  adate_read_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    s_rd(OFS_ADATE) |=> prdata_o == {8'h00, $past(q.adate[23:0])})
    else $error("alarm date read data wrong");
  ready_pulse_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    pready_o |=> !pready_o)
    else $error("ready held too long");
  unmapped_err_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    psel_i && !penable_i && !hit |=> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access without error");
  wren_clear_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    wr_done && addr == OFS_CTRL && !pwdata_i[CTRL_WREN_BIT] |=> !q.wren)
    else $error("write enable not cleared");
  unlock_close_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    wr_done && addr == OFS_CTRL |=> q.unlock == UL_IDLE)
    else $error("unlock left open after control write");
  refused_set_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    q.refused |=> stat[IRQ_REFUSED_BIT])
    else $error("refused write not flagged");
  stat_set_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    alarm_evt_o |=> stat[IRQ_ALARM_BIT])
    else $error("alarm not flagged");
  irq_match_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    irq_o == |(stat & imask))
    else $error("interrupt level wrong");
  half_toggle_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    tick_i |=> q.half != $past(q.half))
    else $error("half second phase not toggled");
  alarm_off_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    tick_i && !q.alarm_en |=> !alarm_evt_o)
    else $error("alarm while disabled");
  evt_once_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    alarm_evt_o && !tick_i |=> !alarm_evt_o)
    else $error("alarm event longer than one cycle");
endmodule // rtcd_regs
`default_nettype wire

// ==== rtcd_pkg.sv ====
// Purpose: shared constants and carriers for the calendar date and alarm registers
// Assumes: 32-bit apb data, byte addresses
// Notes: data layouts are packed structs, msb first
package rtcd_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_UNLOCK = 8'h04;
  localparam logic [7:0] OFS_ALCTL = 8'h08;
  localparam logic [7:0] OFS_DATE = 8'h0c;
  localparam logic [7:0] OFS_ATIME = 8'h10;
  localparam logic [7:0] OFS_ADATE = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_IMASK = 8'h1c;
  // control and alarm control bit positions
  localparam int CTRL_WREN_BIT = 3;
  localparam int CTRL_OPEN_BIT = 0;
  localparam int ALCTL_EN_BIT = 15;
  localparam int ALCTL_MASK_LSB = 8;
  // unlock keys, values arbitrary
  localparam logic [31:0] UNLOCK_KEY1 = 32'h1234_5678;
  localparam logic [31:0] UNLOCK_KEY2 = 32'h8765_4321;
  // interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_ALARM_BIT = 0;
  localparam int IRQ_REFUSED_BIT = 1;
  // alarm period codes
  typedef enum logic [3:0] {
    AM_HALF_SEC, AM_SEC, AM_TEN_SEC, AM_MIN, AM_TEN_MIN,
    AM_HOUR, AM_DAY, AM_WEEK, AM_MONTH, AM_YEAR
  } rtcd_period_code_t;
  typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_OPEN} rtcd_unlock_t;
  // calendar date layout
  typedef struct packed {
    logic [3:0] year_tens_digit;
    logic [3:0] year_units_digit;
    logic [2:0] pad_hi;
    logic month_tens_digit;
    logic [3:0] month_units_digit;
    logic [1:0] pad_mid;
    logic [1:0] monthday_tens_digit;
    logic [3:0] monthday_units_digit;
    logic [4:0] pad_lo;
    logic [2:0] weekday_value;
  } rtcd_date_t;
  // time of day layout
  typedef struct packed {
    logic [1:0] pad_hr;
    logic [1:0] hour_tens_digit;
    logic [3:0] hour_units_digit;
    logic pad_min;
    logic [2:0] minute_tens_digit;
    logic [3:0] minute_units_digit;
    logic pad_sec;
    logic [2:0] second_tens_digit;
    logic [3:0] second_units_digit;
    logic [7:0] pad_lo;
  } rtcd_time_t;
  // whole state of the top module
  typedef struct packed {
    rtcd_date_t date;
    rtcd_time_t atime;
    rtcd_date_t adate;
    rtcd_unlock_t unlock;
    logic wren;
    logic alarm_en;
    logic [3:0] alarm_period_mask;
    logic half;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [IRQ_W-1:0] rd_seen;
    logic alarm_evt;
    logic refused;
  } rtcd_state_t;
endpackage

// ==== rtcd_match.sv ====
// Purpose: alarm comparator over the fields chosen by the period code
// Assumes: inputs are stable bcd values
// Notes: purely combinational, reserved codes never match
`timescale 1ns/1ps
`default_nettype none
module rtcd_match
  import rtcd_pkg::*;
(
  // values
  input wire rtcd_time_t cur_time_i,
  input wire rtcd_date_t cur_date_i,
  input wire rtcd_time_t alm_time_i,
  input wire rtcd_date_t alm_date_i,
  // selection
  input wire logic [3:0] alarm_period_mask_i,
  input wire logic whole_sec_i,
  // result
  output logic match_o
);
  logic su, st, mu, mt, hr, wd, md, mo;
  always_comb begin
    su = cur_time_i.second_units_digit == alm_time_i.second_units_digit;
    st = cur_time_i.second_tens_digit == alm_time_i.second_tens_digit;
    mu = cur_time_i.minute_units_digit == alm_time_i.minute_units_digit;
    mt = cur_time_i.minute_tens_digit == alm_time_i.minute_tens_digit;
    hr = {cur_time_i.hour_tens_digit, cur_time_i.hour_units_digit}
        == {alm_time_i.hour_tens_digit, alm_time_i.hour_units_digit};
    wd = cur_date_i.weekday_value == alm_date_i.weekday_value;
    md = {cur_date_i.monthday_tens_digit, cur_date_i.monthday_units_digit}
        == {alm_date_i.monthday_tens_digit, alm_date_i.monthday_units_digit};
    mo = {cur_date_i.month_tens_digit, cur_date_i.month_units_digit}
        == {alm_date_i.month_tens_digit, alm_date_i.month_units_digit};
    case (alarm_period_mask_i)
      AM_HALF_SEC: match_o = 1'b1;
      AM_SEC: match_o = whole_sec_i;
      AM_TEN_SEC: match_o = whole_sec_i & su;
      AM_MIN: match_o = whole_sec_i & su & st;
      AM_TEN_MIN: match_o = whole_sec_i & su & st & mu;
      AM_HOUR: match_o = whole_sec_i & su & st & mu & mt;
      AM_DAY: match_o = whole_sec_i & su & st & mu & mt & hr;
      AM_WEEK: match_o = whole_sec_i & su & st & mu & mt & hr & wd;
      AM_MONTH: match_o = whole_sec_i & su & st & mu & mt & hr & md;
      AM_YEAR: match_o = whole_sec_i & su & st & mu & mt & hr & md & mo;
      default: match_o = 1'b0;
    endcase
  end
endmodule // rtcd_match
`default_nettype wire

// ==== rtcd_irq.sv ====
// Purpose: sticky event status, mask and one level interrupt
// Assumes: clr_i names only bits software has already seen
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none
module rtcd_irq #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // events and clears
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  // mask write
  input wire logic mask_we_i,
  input wire logic [W-1:0] mask_wd_i,
  // state out
  output logic [W-1:0] stat_o,
  output logic [W-1:0] mask_o,
  output logic irq_o
);
  typedef struct packed {
    logic [W-1:0] stat;
    logic [W-1:0] mask;
    logic irq;
  } rtcd_irq_st_t;
  rtcd_irq_st_t q, next_q;
  always_comb begin
    next_q = q;
    next_q.stat = (q.stat & ~clr_i) | set_i;
    if (mask_we_i) begin
      next_q.mask = mask_wd_i;
    end
    next_q.irq = |(next_q.stat & next_q.mask);
    if (!nrst_i) begin
      next_q = '0;
    end
  end
  always_ff @(posedge clock_i) begin
    q <= next_q;
  end
  assign stat_o = q.stat;
  assign mask_o = q.mask;
  assign irq_o = q.irq;
endmodule // rtcd_irq
`default_nettype wire

// ==== rtcd_tb.sv ====
// Purpose: self-checking bench for the date and alarm register block
// Assumes: zero-wait apb slave, offsets and keys from the package
// Notes: alarm phase is judged over pairs of ticks
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); \
  end \
end
module tb
  import rtcd_pkg::*;
;
  logic clock_i;
  logic nrst_i;
  logic psel_i;
  logic penable_i;
  logic pwrite_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  rtcd_time_t time_i;
  logic tick_i;
  logic alarm_evt_o;
  logic irq_o;
  logic [31:0] rd;
  logic err;
  int miscompares;
  int comparisons;
  int evt_count;

  rtcd_regs #(.AW(8)) DUT (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .time_i(time_i),
    .tick_i(tick_i),
    .alarm_evt_o(alarm_evt_o),
    .irq_o(irq_o)
  );

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  // counts event pulses, one per high cycle
  always @(posedge clock_i) begin
    if (alarm_evt_o === 1'b1) begin
      evt_count = evt_count + 1;
    end
  end

  task automatic test_done;
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one apb transfer, held until pready seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clock_i);
      if (pready_o === 1'b1) break;
    end
    if (i == 16) begin
      miscompares++;
      test_done();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // one-cycle tick, then let status and irq settle
  task automatic tick;
    @(posedge clock_i);
    tick_i <= 1'b1;
    @(posedge clock_i);
    tick_i <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask

  task automatic alarm_run(input int code, input int exp);
    int c0;
    apb(1'b1, OFS_ALCTL, 32'h8000 | (32'(code) << 8));
    c0 = evt_count;
    tick();
    tick();
    `CHK(evt_count - c0, exp)
  endtask

  task automatic t_reset;
    `CHK(irq_o, 1'b0)
    `CHK(alarm_evt_o, 1'b0)
    rd_chk(OFS_CTRL, 32'h0);
    rd_chk(OFS_ALCTL, 32'h0);
    rd_chk(OFS_STAT, 32'h0);
    rd_chk(OFS_IMASK, 32'h0);
  endtask

  task automatic t_lock;
    apb(1'b1, OFS_CTRL, 32'h8);
    rd_chk(OFS_CTRL, 32'h0);
    apb(1'b1, OFS_UNLOCK, UNLOCK_KEY1);
    apb(1'b1, OFS_CTRL, 32'h8);
    rd_chk(OFS_CTRL, 32'h0);
    apb(1'b1, OFS_DATE, 32'h0);
    rd_chk(OFS_STAT, 32'h2);
    rd_chk(OFS_STAT, 32'h0);
  endtask

  task automatic t_fields;
    apb(1'b1, OFS_UNLOCK, UNLOCK_KEY1);
    apb(1'b1, OFS_UNLOCK, UNLOCK_KEY2);
    apb(1'b1, OFS_CTRL, 32'h8);
    rd_chk(OFS_CTRL, 32'h8);
    apb(1'b1, OFS_DATE, 32'h99f9f9fe);
    rd_chk(OFS_DATE, 32'h99193906);
    apb(1'b1, OFS_ATIME, 32'he9d9d9ff);
    rd_chk(OFS_ATIME, 32'h29595900);
    apb(1'b1, OFS_ADATE, 32'hfff9f9fe);
    rd_chk(OFS_ADATE, 32'h00193906);
    apb(1'b1, OFS_DATE, 32'h25123106);
    rd_chk(OFS_DATE, 32'h25123106);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_DATE, 32'h0);
    rd_chk(OFS_DATE, 32'h25123106);
    rd_chk(OFS_STAT, 32'h2);
  endtask

  task automatic t_unmapped;
    apb(1'b0, 8'h20, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    apb(1'b1, 8'h24, 32'hffffffff);
    `CHK(err, 1'b1)
    apb(1'b0, OFS_ATIME, 32'h0);
    `CHK(err, 1'b0)
  endtask

  task automatic t_alarm;
    apb(1'b1, OFS_IMASK, 32'h1);
    apb(1'b1, OFS_ATIME, 32'h12345600);
    apb(1'b1, OFS_ADATE, 32'h00123106);
    time_i <= rtcd_time_t'(32'h12345600);
    for (int c = 0; c < 16; c++) begin
      alarm_run(c, (c == 0) ? 2 : ((c < 10) ? 1 : 0));
    end
    `CHK(irq_o, 1'b1)
    rd_chk(OFS_STAT, 32'h1);
    repeat (2) @(posedge clock_i);
    `CHK(irq_o, 1'b0)
    time_i <= rtcd_time_t'(32'h12345700);
    alarm_run(2, 0);
    alarm_run(1, 1);
    apb(1'b1, OFS_IMASK, 32'h0);
    rd_chk(OFS_STAT, 32'h1);
    alarm_run(0, 2);
    `CHK(irq_o, 1'b0)
    rd_chk(OFS_STAT, 32'h1);
    time_i <= rtcd_time_t'(32'h12344600);
    alarm_run(2, 1);
    alarm_run(3, 0);
    time_i <= rtcd_time_t'(32'h12355600);
    alarm_run(3, 1);
    alarm_run(4, 0);
    time_i <= rtcd_time_t'(32'h12445600);
    alarm_run(4, 1);
    alarm_run(5, 0);
    time_i <= rtcd_time_t'(32'h13345600);
    alarm_run(5, 1);
    alarm_run(6, 0);
    time_i <= rtcd_time_t'(32'h12345600);
    apb(1'b1, OFS_ADATE, 32'h00123005);
    alarm_run(6, 1);
    alarm_run(7, 0);
    alarm_run(8, 0);
    apb(1'b1, OFS_ADATE, 32'h00123105);
    alarm_run(7, 0);
    alarm_run(8, 1);
    alarm_run(9, 1);
    apb(1'b1, OFS_ADATE, 32'h00113106);
    alarm_run(7, 1);
    alarm_run(9, 0);
  endtask

  initial begin
    miscompares = 0;
    comparisons = 0;
    evt_count = 0;
    nrst_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    tick_i = 1'b0;
    time_i = rtcd_time_t'(32'h0);
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    t_reset();
    t_lock();
    t_fields();
    t_unmapped();
    t_alarm();
    test_done();
  end
endmodule // tb
`default_nettype wire
